/* rtl/gate_driver_pwm_sensor_config.sv */
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - mode field picks six, three or single pwm input commutation scheme
// - single pwm modes: freewheel bit 0 active freewheeling, 1 diode freewheeling
// - brake code 00 low side, 01 high side, 10 all outputs high impedance
// - brake code 11 alternates low and high side on each brake event
// - recirculation bit enables alternating recirculation only while mode is 011
// - reserved upper bits of both configuration registers read as zero
// - hall inputs deglitched for code times 640 ns, code 0 none
// - over-temperature shuts down unless the inhibit bit is set
// - timing 00: sense outputs active while low side gate is high
// - timing 01: sense outputs active while high side gate is low
// - timing upper bit set: sense outputs always active
module gate_driver_pwm_sensor_config (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // pins from the controller and sensors
    input wire logic [5:0] pwm_i,
    input wire logic [2:0] hall_i,
    input wire logic brake_i,
    input wire logic overtemp_i,
    // gate and sense outputs
    output logic [2:0] high_side_gate_signal_o,
    output logic [2:0] low_side_gate_signal_o,
    output logic gate_highz_o,
    output logic shutdown_o,
    output logic [2:0] sense_amp_enable_o
);
    typedef struct packed {
        logic [10:0] sync1;
        logic [10:0] sync2;
        logic pwm0_prev;
        logic brake_prev;
        logic brake_side;
        logic toggle_next;
        logic recirc_side;
        logic [15:0] pwm_cfg;
        logic [15:0] sense_cfg;
        logic ack;
        logic [31:0] rdata;
        logic [2:0] gh;
        logic [2:0] gl;
        logic [2:0] sense;
        logic highz;
        logic shut;
    } cfg_state_type;

    cfg_state_type st;
    cfg_state_type nx;

    logic [5:0] pwm_s;
    logic [2:0] hall_s;
    logic brake_s;
    logic ot_s;
    logic [2:0] hall_f;
    logic [2:0] mode;
    logic freewheel_style_select;
    logic [1:0] brake_code;
    logic alternating_recirculation_enable;
    logic [3:0] degl_code;
    logic overtemp_shutdown_inhibit;
    logic [1:0] sense_amp_timing_select;
    logic req;
    logic [15:0] status;
    logic [15:0] wr_val;
    logic [5:0] hall_pair;

    hall_filter_if hf ();

    hall_deglitch u_degl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hf(hf.filter)
    );

    // only the second stage feeds logic; the first is read by nothing else
    assign pwm_s = st.sync2[5:0];
    assign hall_s = st.sync2[8:6];
    assign brake_s = st.sync2[9];
    assign ot_s = st.sync2[10];

    assign hf.raw = hall_s;
    assign hf.code = degl_code;
    assign hall_f = hf.filtered;

    assign mode = st.pwm_cfg[gd_cfg_pkg::MODE_MSB:gd_cfg_pkg::MODE_LSB];
    assign freewheel_style_select = st.pwm_cfg[gd_cfg_pkg::FREEW_BIT];
    assign brake_code = st.pwm_cfg[gd_cfg_pkg::BRAKE_MSB:gd_cfg_pkg::BRAKE_LSB];
    assign alternating_recirculation_enable = st.pwm_cfg[gd_cfg_pkg::RECIRC_BIT];
    assign degl_code = st.sense_cfg[gd_cfg_pkg::DEGL_MSB:gd_cfg_pkg::DEGL_LSB];
    assign overtemp_shutdown_inhibit = st.sense_cfg[gd_cfg_pkg::OTS_BIT];
    assign sense_amp_timing_select = st.sense_cfg[gd_cfg_pkg::CST_MSB:gd_cfg_pkg::CST_LSB];

    assign req = cyc_i & stb_i;
    assign wr_val = {8'h00, dat_i[7:0]};

    always_comb begin
        status = 16'h0000;
        status[gd_cfg_pkg::ST_HALL_MSB:gd_cfg_pkg::ST_HALL_LSB] = hall_f;
        status[gd_cfg_pkg::ST_SIDE_BIT] = st.brake_side;
        status[gd_cfg_pkg::ST_SHUT_BIT] = st.shut;
        status[gd_cfg_pkg::ST_HIGHZ_BIT] = st.highz;
    end

    // hall code to one-hot high and low phases; invalid codes drive nothing
    function automatic logic [5:0] hall_step(input logic [2:0] h);
        logic [5:0] r;
        r = 6'h00;
        case (h)
            3'h1: r = {3'h1, 3'h2};
            3'h3: r = {3'h1, 3'h4};
            3'h2: r = {3'h2, 3'h4};
            3'h6: r = {3'h2, 3'h1};
            3'h4: r = {3'h4, 3'h1};
            3'h5: r = {3'h4, 3'h2};
            default: r = 6'h00;
        endcase
        return r;
    endfunction

    // decoded phases kept as a net so the checks can look back at them
    assign hall_pair = hall_step(hall_f);

    always_comb begin
        logic [2:0] hi;
        logic [2:0] lo;
        logic [2:0] gh_n;
        logic [2:0] gl_n;
        logic hz_n;
        logic shut_n;
        logic brake_rise;
        logic side;
        logic recirc_on;
        hi = 3'h0;
        lo = 3'h0;
        gh_n = 3'h0;
        gl_n = 3'h0;
        hz_n = 1'b0;
        shut_n = 1'b0;
        brake_rise = 1'b0;
        side = 1'b0;
        recirc_on = 1'b0;
        nx = st;

        nx.sync1 = {overtemp_i, brake_i, hall_i, pwm_i};
        nx.sync2 = st.sync1;

        // bus: read data ready with ack, write lands on the ack edge
        nx.ack = req & ~st.ack;
        if (req & ~st.ack & ~we_i) begin
            case (adr_i[7:2])
                gd_cfg_pkg::PWM_CFG_IDX: nx.rdata = {16'h0000, st.pwm_cfg};
                gd_cfg_pkg::SENSE_CFG_IDX: nx.rdata = {16'h0000, st.sense_cfg};
                gd_cfg_pkg::STATUS_IDX: nx.rdata = {16'h0000, status};
                default: nx.rdata = 32'h0000_0000;
            endcase
        end
        if (req & st.ack & we_i & sel_i[0]) begin
            case (adr_i[7:2])
                gd_cfg_pkg::PWM_CFG_IDX: nx.pwm_cfg = wr_val & gd_cfg_pkg::PWM_CFG_MASK;
                gd_cfg_pkg::SENSE_CFG_IDX: begin
                    nx.sense_cfg = wr_val & gd_cfg_pkg::SENSE_CFG_MASK;
                end
                default: nx.sense_cfg = st.sense_cfg;
            endcase
        end

        // brake events and the alternating side
        brake_rise = brake_s & ~st.brake_prev;
        nx.brake_prev = brake_s;
        side = st.brake_side;
        if (brake_rise && brake_code == gd_cfg_pkg::BRAKE_TOGGLE) begin
            side = st.toggle_next;
            nx.brake_side = st.toggle_next;
            nx.toggle_next = ~st.toggle_next;
        end

        // recirculation side flips once per pwm period, only in mode 011
        recirc_on = alternating_recirculation_enable
            && mode == gd_cfg_pkg::MODE_SINGLE_HALL;
        nx.pwm0_prev = pwm_s[0];
        if (recirc_on && !pwm_s[0] && st.pwm0_prev) begin
            nx.recirc_side = ~st.recirc_side;
        end

        {hi, lo} = hall_step(hall_f);
        shut_n = ot_s & ~overtemp_shutdown_inhibit;

        if (shut_n) begin
            hz_n = 1'b1;
        end else if (brake_s) begin
            case (brake_code)
                gd_cfg_pkg::BRAKE_LOW: gl_n = 3'h7;
                gd_cfg_pkg::BRAKE_HIGH: gh_n = 3'h7;
                gd_cfg_pkg::BRAKE_HIGHZ: hz_n = 1'b1;
                default: begin
                    if (side) begin
                        gh_n = 3'h7;
                    end else begin
                        gl_n = 3'h7;
                    end
                end
            endcase
        end else begin
            case (mode)
                gd_cfg_pkg::MODE_SIX: begin
                    gh_n = pwm_s[2:0];
                    gl_n = pwm_s[5:3];
                end
                gd_cfg_pkg::MODE_THREE: begin
                    gh_n = pwm_s[2:0];
                    gl_n = ~pwm_s[2:0];
                end
                gd_cfg_pkg::MODE_SINGLE, gd_cfg_pkg::MODE_SINGLE_HALL: begin
                    if (pwm_s[0]) begin
                        gh_n = hi;
                        gl_n = lo;
                    end else if (recirc_on && st.recirc_side) begin
                        gh_n = hi | lo;
                    end else if (recirc_on || !freewheel_style_select) begin
                        gl_n = hi | lo;
                    end else begin
                        gl_n = lo;
                    end
                end
                // reserved codes leave every gate off
                default: begin
                    gh_n = 3'h0;
                    gl_n = 3'h0;
                end
            endcase
        end

        nx.gh = gh_n;
        nx.gl = gl_n;
        nx.highz = hz_n;
        nx.shut = shut_n;
        if (sense_amp_timing_select[1]) begin
            nx.sense = 3'h7;
        end else if (sense_amp_timing_select == gd_cfg_pkg::CST_HIGH_OFF) begin
            nx.sense = ~gh_n;
        end else begin
            nx.sense = gl_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.pwm_cfg <= gd_cfg_pkg::PWM_CFG_RESET;
            st.sense_cfg <= gd_cfg_pkg::SENSE_CFG_RESET;
        end else begin
            st <= nx;
        end
    end

    assign dat_o = st.rdata;
    assign ack_o = st.ack;
    assign high_side_gate_signal_o = st.gh;
    assign low_side_gate_signal_o = st.gl;
    assign gate_highz_o = st.highz;
    assign shutdown_o = st.shut;
    assign sense_amp_enable_o = st.sense;

    chk_six_pwm_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == gd_cfg_pkg::MODE_SIX && !brake_s && !(ot_s && !overtemp_shutdown_inhibit))
        |=> (st.gh == $past(pwm_s[2:0]) && st.gl == $past(pwm_s[5:3])))
        else $error("six input mode gates do not follow pwm inputs");

    chk_three_pwm_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == gd_cfg_pkg::MODE_THREE && !brake_s && !ot_s)
        |=> (st.gh == $past(pwm_s[2:0]) && st.gl == ~st.gh))
        else $error("three input mode gates not complementary");

    chk_diode_freewheel: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == gd_cfg_pkg::MODE_SINGLE && freewheel_style_select && !pwm_s[0]
            && !brake_s && !ot_s)
        |=> (st.gh == 3'h0 && st.gl == $past(hall_pair[2:0])))
        else $error("diode freewheel drove a recirculating switch");

    chk_brake_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (brake_s && brake_code == gd_cfg_pkg::BRAKE_LOW && !ot_s)
        |=> (st.gl == 3'h7 && st.gh == 3'h0 && !st.highz))
        else $error("low side brake not applied");

    chk_brake_highz: assert property (@(posedge clk_i) disable iff (rst_i)
        (brake_s && brake_code == gd_cfg_pkg::BRAKE_HIGHZ)
        |=> (st.highz && st.gh == 3'h0 && st.gl == 3'h0))
        else $error("high impedance brake not applied");

    chk_brake_alternate: assert property (@(posedge clk_i) disable iff (rst_i)
        (brake_s && !st.brake_prev && brake_code == gd_cfg_pkg::BRAKE_TOGGLE && !ot_s)
        |=> (st.toggle_next != $past(st.toggle_next)
            && (st.brake_side ? st.gh == 3'h7 : st.gl == 3'h7)))
        else $error("toggle brake did not alternate sides");

    chk_recirc_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode != gd_cfg_pkg::MODE_SINGLE_HALL) |=> $stable(st.recirc_side))
        else $error("recirculation acted outside its mode");

    chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> (dat_o[31:7] == 25'h0000000 && st.pwm_cfg[15:7] == 9'h000
            && st.sense_cfg[15:7] == 9'h000))
        else $error("reserved bits not zero");

    chk_overtemp_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (ot_s && !overtemp_shutdown_inhibit)
        |=> (shutdown_o && st.gh == 3'h0 && st.gl == 3'h0))
        else $error("over-temperature did not shut down");

    chk_overtemp_inhibit: assert property (@(posedge clk_i) disable iff (rst_i)
        overtemp_shutdown_inhibit |=> !shutdown_o)
        else $error("shutdown while inhibited");

    chk_sense_low_on: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(sense_amp_timing_select) == gd_cfg_pkg::CST_LOW_ON) |-> (st.sense == st.gl))
        else $error("sense not tied to low side gate");

    chk_sense_high_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(sense_amp_timing_select) == gd_cfg_pkg::CST_HIGH_OFF) |-> (st.sense == ~st.gh))
        else $error("sense not tied to high side gate");

    chk_sense_always: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(sense_amp_timing_select[1]) |-> (st.sense == 3'h7))
        else $error("sense not always active");

    chk_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && st.ack && we_i && sel_i[0] && adr_i[7:2] == gd_cfg_pkg::PWM_CFG_IDX)
        |=> (st.pwm_cfg == ($past(wr_val) & gd_cfg_pkg::PWM_CFG_MASK)))
        else $error("drive configuration write not stored");

    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

/* rtl/gd_cfg_pkg.sv */
package gd_cfg_pkg;

    // clock and hall deglitch timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALL_STEP_NS = 640;
    localparam int HALL_MAX_NS = 9600;
    localparam int HALL_STEP_CYC = (HALL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALL_MAX_CYC = (HALL_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALL_CNT_W = $clog2(HALL_MAX_CYC + 1);

    // register word indices; byte address is four times the index
    localparam logic [5:0] PWM_CFG_IDX = 6'h13;
    localparam logic [5:0] SENSE_CFG_IDX = 6'h14;
    localparam logic [5:0] STATUS_IDX = 6'h18;

    // reset values and writable bits
    localparam logic [15:0] PWM_CFG_RESET = 16'h0000;
    localparam logic [15:0] SENSE_CFG_RESET = 16'h0000;
    localparam logic [15:0] PWM_CFG_MASK = 16'h007f;
    localparam logic [15:0] SENSE_CFG_MASK = 16'h007f;

    // drive configuration field positions
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int FREEW_BIT = 3;
    localparam int BRAKE_LSB = 4;
    localparam int BRAKE_MSB = 5;
    localparam int RECIRC_BIT = 6;

    // sensing configuration field positions
    localparam int DEGL_LSB = 0;
    localparam int DEGL_MSB = 3;
    localparam int OTS_BIT = 4;
    localparam int CST_LSB = 5;
    localparam int CST_MSB = 6;

    // status field positions
    localparam int ST_HALL_LSB = 0;
    localparam int ST_HALL_MSB = 2;
    localparam int ST_SIDE_BIT = 3;
    localparam int ST_SHUT_BIT = 4;
    localparam int ST_HIGHZ_BIT = 5;

    // commutation input schemes
    localparam logic [2:0] MODE_SIX = 3'h0;
    localparam logic [2:0] MODE_THREE = 3'h1;
    localparam logic [2:0] MODE_SINGLE = 3'h2;
    localparam logic [2:0] MODE_SINGLE_HALL = 3'h3;

    // brake schemes
    localparam logic [1:0] BRAKE_LOW = 2'h0;
    localparam logic [1:0] BRAKE_HIGH = 2'h1;
    localparam logic [1:0] BRAKE_HIGHZ = 2'h2;
    localparam logic [1:0] BRAKE_TOGGLE = 2'h3;

    // sense amplifier timing
    localparam logic [1:0] CST_LOW_ON = 2'h0;
    localparam logic [1:0] CST_HIGH_OFF = 2'h1;

endpackage

/* rtl/hall_filter_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface hall_filter_if;
    logic [2:0] raw;
    logic [3:0] code;
    logic [2:0] filtered;

    modport filter (input raw, input code, output filtered);
    modport user (output raw, output code, input filtered);
endinterface

`default_nettype wire

/* rtl/hall_deglitch.sv */
`timescale 1ns/1ps
`default_nettype none

module hall_deglitch (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // filter connection
    hall_filter_if.filter hf
);
    localparam int CW = gd_cfg_pkg::HALL_CNT_W;
    localparam logic [CW-1:0] STEP = CW'(gd_cfg_pkg::HALL_STEP_CYC);
    localparam logic [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

    typedef struct packed {
        logic [2:0] cand;
        logic [2:0] filt;
        logic [CW-1:0] cnt;
    } degl_state_type;

    degl_state_type st;
    degl_state_type nx;
    logic [CW-1:0] lim;

    assign lim = CW'({{(CW-4){1'b0}}, hf.code} * STEP);
    assign hf.filtered = st.filt;

    always_comb begin
        nx = st;
        if (hf.code == 4'h0) begin
            nx.filt = hf.raw;
            nx.cand = hf.raw;
            nx.cnt = '0;
        end else if (hf.raw != st.cand) begin
            nx.cand = hf.raw;
            nx.cnt = '0;
        end else if (st.cand == st.filt) begin
            nx.cnt = '0;
        end else if (st.cnt >= lim - ONE) begin
            nx.filt = st.cand;
            nx.cnt = '0;
        end else begin
            nx.cnt = st.cnt + ONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    chk_degl_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
        (hf.code == 4'h0) |=> (st.filt == $past(hf.raw)))
        else $error("hall bypass did not follow input");

    chk_degl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (hf.code != 4'h0 && !(hf.raw == st.cand && st.cand != st.filt && st.cnt >= lim - ONE))
        |=> $stable(st.filt))
        else $error("hall output changed before deglitch time");

endmodule

`default_nettype wire

/* verification/pwm_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none

// controller timer: one pwm channel on bit 0 while running, the rest held static
module pwm_timer_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control from the bench
    input wire logic run_i,
    input wire logic [5:0] level_i,
    // pins toward the driver
    output logic [5:0] pwm_o
);
    logic [3:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // 16-cycle period, high for 6: both levels outlast the pin synchronisers
    assign pwm_o = run_i ? {level_i[5:1], cnt_r < 4'h6} : level_i;
endmodule

`default_nettype wire

/* verification/gate_driver_pwm_sensor_config_test.sv */
`timescale 1ns/1ps
`default_nettype none

module gate_driver_pwm_sensor_config_test;
    localparam logic [7:0] DRV = 8'h4c;
    localparam logic [7:0] SNS = 8'h50;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, brake_i, overtemp_i, run, ack_o, hz, sd, s1;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [5:0] pwm_i, level;
    logic [2:0] hall_i, gh, gl, sense;
    int bad_count, n_compared;

    pwm_timer_model pwm_timer_model_inst (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
        .level_i(level), .pwm_o(pwm_i));

    gate_driver_pwm_sensor_config gate_driver_pwm_sensor_config_inst (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pwm_i(pwm_i),
        .hall_i(hall_i), .brake_i(brake_i), .overtemp_i(overtemp_i),
        .high_side_gate_signal_o(gh), .low_side_gate_signal_o(gl), .gate_highz_o(hz),
        .shutdown_o(sd), .sense_amp_enable_o(sense));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // classic cycle: request held until ack is seen, data taken from that same cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        n = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        chk({31'h0, n < 20}, 32'h1);
        if (n == 20) begin
            end_sim();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // firmware never writes the hall single mode or reserved mode codes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(rd, e);
    endtask

    // pins are driven, then held for cyc cycles before sampling on the falling edge
    task automatic pins(input logic [5:0] p, input logic [2:0] h, input logic b, input logic t,
        input int cyc);
        @(posedge clk_i);
        level <= p;
        hall_i <= h;
        brake_i <= b;
        overtemp_i <= t;
        repeat (cyc) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic t_regs;
        rdc(DRV, 32'h0);
        rdc(SNS, 32'h0);
        wr(DRV, 32'hfffffffa);
        rdc(DRV, 32'h7a);
        wr(SNS, 32'hffffffff);
        rdc(SNS, 32'h7f);
        wb(1'b1, SNS, 32'h0, 4'he);
        rdc(SNS, 32'h7f);
        wr(8'h80, 32'h1234);
        rdc(8'h80, 32'h0);
        wr(DRV, 32'h0);
        wr(SNS, 32'h0);
    endtask

    task automatic t_six_sense;
        logic [2:0] e[4];
        e = '{3'h4, 3'h5, 3'h7, 3'h7};
        wr(DRV, 32'h0);
        pins(6'b100_010, 3'h1, 1'b0, 1'b0, 8);
        chk({gh, gl}, {3'b010, 3'b100});
        for (int c = 0; c < 4; c++) begin
            wr(SNS, 32'(c) << 5);
            repeat (2) @(negedge clk_i);
            chk(sense, e[c]);
        end
        wr(SNS, 32'h0);
    endtask

    task automatic t_three;
        wr(DRV, 32'h1);
        pins(6'b111_101, 3'h1, 1'b0, 1'b0, 8);
        chk(gh, 3'b101);
        chk(gl, 3'b010);
    endtask

    task automatic t_single;
        wr(DRV, 32'h2);
        pins(6'b000_001, 3'h1, 1'b0, 1'b0, 8);
        chk({gh, gl}, {3'b001, 3'b010});
        pins(6'b000_000, 3'h1, 1'b0, 1'b0, 8);
        chk({gh, gl}, {3'b000, 3'b011});
        wr(DRV, 32'ha);
        repeat (2) @(negedge clk_i);
        chk({gh, gl}, {3'b000, 3'b010});
    endtask

    // recirculation bit outside mode 011 must leave active freewheeling untouched
    task automatic t_recirc;
        int hi;
        hi = 0;
        wr(DRV, 32'h42);
        run <= 1'b1;
        repeat (8) @(posedge clk_i);
        repeat (100) begin
            @(negedge clk_i);
            if (gh === 3'b000) begin
                chk(gl, 3'b011);
            end else begin
                hi++;
                chk({gh, gl}, {3'b001, 3'b010});
            end
        end
        chk({31'h0, hi > 0}, 32'h1);
        @(posedge clk_i);
        run <= 1'b0;
    endtask

    task automatic t_brake;
        wr(DRV, 32'h0);
        pins(6'h0, 3'h1, 1'b1, 1'b0, 8);
        chk({hz, gh, gl}, {1'b0, 3'b000, 3'b111});
        wr(DRV, 32'h10);
        repeat (2) @(negedge clk_i);
        chk({hz, gh, gl}, {1'b0, 3'b111, 3'b000});
        wr(DRV, 32'h20);
        repeat (2) @(negedge clk_i);
        chk({hz, gh, gl}, {1'b1, 3'b000, 3'b000});
        pins(6'h0, 3'h1, 1'b0, 1'b0, 8);
        wr(DRV, 32'h30);
        pins(6'h0, 3'h1, 1'b1, 1'b0, 8);
        // the first toggle event after reset brakes through the low side
        s1 = 1'b0;
        chk({gh, gl}, s1 ? 6'b111_000 : 6'b000_111);
        for (int k = 0; k < 2; k++) begin
            pins(6'h0, 3'h1, 1'b0, 1'b0, 8);
            pins(6'h0, 3'h1, 1'b1, 1'b0, 8);
            s1 = ~s1;
            chk({gh, gl}, s1 ? 6'b111_000 : 6'b000_111);
        end
        pins(6'h0, 3'h1, 1'b0, 1'b0, 8);
    endtask

    task automatic t_overtemp;
        wr(DRV, 32'h0);
        pins(6'b000_010, 3'h1, 1'b0, 1'b1, 8);
        chk({sd, hz, gh, gl}, 8'b11_000_000);
        rdc(8'h60, 32'h31);
        wr(SNS, 32'h10);
        repeat (2) @(negedge clk_i);
        chk({sd, hz, gh, gl}, 8'b00_010_000);
        pins(6'b000_010, 3'h1, 1'b0, 1'b0, 8);
        wr(SNS, 32'h0);
    endtask

    task automatic t_deglitch;
        wr(DRV, 32'h2);
        wr(SNS, 32'h1);
        pins(6'b000_001, 3'h1, 1'b0, 1'b0, 100);
        pins(6'b000_001, 3'h2, 1'b0, 1'b0, 50);
        chk(gh, 3'b001);
        repeat (30) @(negedge clk_i);
        chk(gh, 3'b010);
        wr(SNS, 32'hf);
        pins(6'b000_001, 3'h1, 1'b0, 1'b0, 900);
        chk(gh, 3'b010);
        repeat (100) @(negedge clk_i);
        chk(gh, 3'b001);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h0;
        sel_i = 4'h0;
        dat_i = 32'h0;
        hall_i = 3'h1;
        brake_i = 1'b0;
        overtemp_i = 1'b0;
        level = 6'h0;
        run = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_six_sense();
        t_three();
        t_single();
        t_recirc();
        t_brake();
        t_overtemp();
        t_deglitch();
        end_sim();
    end
endmodule

`default_nettype wire
